// ===== include/mdm_pkg.sv
/*
 * constants for the multiply, multiply-accumulate and divide coprocessor:
 * mode word layout, operation codes, output selections, division timing.
 * assumes a 16-bit core issuing coprocessor instructions on one clock.
 */
package mdm_pkg;
	localparam int unsigned MODE_WIDTH       = 7;
	localparam int unsigned OP_LSB           = 0;
	localparam int unsigned OP_WIDTH         = 4;
	localparam int unsigned OUT_LSB          = 4;
	localparam int unsigned OUT_WIDTH        = 3;
	localparam logic [6:0]  MODE_RESET       = 7'h00;
	localparam logic [31:0] RESULT_RESET     = 32'h0000_0000;

	// operation codes held in mode bits 3..0
	typedef enum logic [3:0] {
		OP_CLEAR    = 4'h0,
		OP_LOAD16   = 4'h1,
		OP_LOAD32_0 = 4'h2,
		OP_READ     = 4'h3,
		OP_MUL_U    = 4'h4,
		OP_MUL_S    = 4'h5,
		OP_MAC_U    = 4'h6,
		OP_MAC_S    = 4'h7,
		OP_DIV_U    = 4'h8,
		OP_DIV_S    = 4'h9,
		OP_LOAD32_1 = 4'hA
	} op_type;

	// output selections held in mode bits 6..4
	localparam logic [2:0] OUT_R0_LO = 3'h0;
	localparam logic [2:0] OUT_R0_HI = 3'h1;
	localparam logic [2:0] OUT_R1_LO = 3'h2;
	localparam logic [2:0] OUT_R1_HI = 3'h3;

	// division latency: one cycle to start plus one per iteration until done
	localparam int unsigned DIV_BITS       = 32;
	localparam int unsigned DIV_STEPS      = 16;
	localparam int unsigned DIV_MIN_CYCLES = 17;
	localparam int unsigned DIV_MAX_CYCLES = 20;
	localparam logic [4:0]  DIV_LAST_STEP  = 5'(DIV_STEPS - 1);
endpackage

// ===== src/div_core.sv
/*
 * iterative 32 by 32 divider, two quotient bits per cycle, signed or unsigned.
 * assumes start is a one-cycle pulse and operands stay free after start.
 */
`timescale 1ns/100ps
`default_nettype none
module div_core (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic        signed_op,
	input  wire logic [31:0] dividend,
	input  wire logic [31:0] divisor,
	output logic             busy,
	output logic             done,
	output logic      [31:0] quotient,
	output logic      [31:0] remainder
);
	logic [31:0] quo_reg;
	logic [32:0] rem_reg;
	logic [31:0] dvs_reg;
	logic [4:0]  step_reg;
	logic        negq_reg;
	logic        negr_reg;
	logic        fin_reg;
	logic [32:0] r1;
	logic [32:0] r2;
	logic [32:0] t1;
	logic [32:0] t2;
	logic        q1;
	logic        q2;

	// two restoring steps per clock keeps the loop at sixteen cycles
	always_comb begin
		r1 = {rem_reg[31:0], quo_reg[31]};
		t1 = r1 - {1'b0, dvs_reg};
		q1 = ~t1[32];
		if (q1) begin
			r1 = t1;
		end
		r2 = {r1[31:0], quo_reg[30]};
		t2 = r2 - {1'b0, dvs_reg};
		q2 = ~t2[32];
		if (q2) begin
			r2 = t2;
		end
	end

	// iteration control; negative operands are made magnitudes at start
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			quo_reg  <= 32'h0000_0000;
			rem_reg  <= 33'h0_0000_0000;
			dvs_reg  <= 32'h0000_0000;
			step_reg <= 5'h00;
			negq_reg <= 1'b0;
			negr_reg <= 1'b0;
			busy     <= 1'b0;
			fin_reg  <= 1'b0;
		end else begin
			fin_reg <= 1'b0;
			if (start) begin
				quo_reg  <= (signed_op && dividend[31]) ? 32'(-dividend) : dividend;
				dvs_reg  <= (signed_op && divisor[31]) ? 32'(-divisor) : divisor;
				rem_reg  <= 33'h0_0000_0000;
				negq_reg <= signed_op && (dividend[31] ^ divisor[31]);
				negr_reg <= signed_op && dividend[31];
				step_reg <= 5'h00;
				busy     <= 1'b1;
			end else if (busy) begin
				quo_reg  <= {quo_reg[29:0], q1, q2};
				rem_reg  <= r2;
				step_reg <= 5'(step_reg + 5'h01);
				if (step_reg == mdm_pkg::DIV_LAST_STEP) begin
					busy    <= 1'b0;
					fin_reg <= 1'b1;
				end
			end
		end
	end

	// sign fix-up on the way out; zero divisor gives no defined answer
	assign done      = fin_reg;
	assign quotient  = negq_reg ? 32'(-quo_reg) : quo_reg;
	assign remainder = negr_reg ? 32'(-rem_reg[31:0]) : rem_reg[31:0];
endmodule
`default_nettype wire

// ===== src/mul_div_mac_coprocessor.sv
/*
 * multiply, multiply-accumulate and divide coprocessor with two 32-bit
 * result registers and a 16-bit selectable output half.
 * assumes the core holds off further instructions while busy is high and
 * that all inputs come from logic on clk_sys.
 */
// Contract
// - op 4 unsigned, op 5 signed 16x16 multiply, 32-bit product, one cycle.
// - op 6/7 add product to 32-bit accumulator in one cycle, flag overflow.
// - op 8/9 divide 32-bit dividend by 32-bit divisor, quotient and remainder.
// - division completes within seventeen to twenty clock cycles.
// - overflow and zero divisor undefined; core must not rely on them.
// - core writes seven-bit mode word from register or immediate bits 6..0.
// - mode bits 6..4 pick output half of result registers; 4..7 reserved.
// - op 0 clears both result registers to zero.
// - op 1 loads 16-bit augend into low half of result register zero.
// - op 2 loads 32 bits into result zero; op A into result one.
// - op 3 computes nothing, only presents the selected half.
// - multiply stores product in result zero and clears all four flags.
// - divide uses result zero as dividend; quotient to zero, remainder one.
// - result registers hold their value until a later operation writes them.
`timescale 1ns/100ps
`default_nettype none
module mul_div_mac_coprocessor (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        mode_write_instruction,
	input  wire logic [6:0]  mode_data,
	input  wire logic        operate_and_read_instruction,
	input  wire logic        preload_result_instruction,
	input  wire logic [15:0] operand_a,
	input  wire logic [15:0] operand_b,
	output logic      [15:0] copro_out,
	output logic      [3:0]  carry_overflow_zero_negative_flags,
	output logic             busy,
	output logic      [6:0]  mode_out
);
	logic [6:0]  operation_output_mode_select_reg;
	logic [31:0] result_register_zero;
	logic [31:0] result_register_one;
	logic [3:0]  flags_reg;
	logic [15:0] out_reg;
	logic [15:0] out_next;
	logic [3:0]  op;
	logic [2:0]  outsel;
	logic [31:0] prod_u;
	logic [31:0] prod_s;
	logic [31:0] prod;
	logic [32:0] mac_u;
	logic [32:0] mac_s;
	logic [31:0] mac_sum;
	logic        mac_ovf;
	logic        is_signed;
	logic        div_start;
	logic        div_busy;
	logic        div_done;
	logic [31:0] div_quo;
	logic [31:0] div_rem;
	logic [31:0] r0_next;
	logic [31:0] r1_next;
	logic        out_pending_reg;

	assign op     = operation_output_mode_select_reg[mdm_pkg::OP_LSB +: mdm_pkg::OP_WIDTH];
	assign outsel = operation_output_mode_select_reg[mdm_pkg::OUT_LSB +: mdm_pkg::OUT_WIDTH];
	assign is_signed = op[0];

	// mode word written by the mode write instruction, low seven bits only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			operation_output_mode_select_reg <= mdm_pkg::MODE_RESET;
		end else if (mode_write_instruction && !div_busy) begin
			operation_output_mode_select_reg <= mode_data;
		end
	end

	// single-cycle arithmetic, both sign flavours built in parallel
	always_comb begin
		prod_u  = {16'h0000, operand_a} * {16'h0000, operand_b};
		prod_s  = {{16{operand_a[15]}}, operand_a} * {{16{operand_b[15]}}, operand_b};
		prod    = is_signed ? prod_s : prod_u;
		mac_u   = {1'b0, result_register_zero} + {1'b0, prod_u};
		mac_s   = 33'($signed({result_register_zero[31], result_register_zero})
			+ $signed({prod_s[31], prod_s}));
		mac_sum = is_signed ? mac_s[31:0] : mac_u[31:0];
		// signed overflow when the two sign-extended top bits disagree
		mac_ovf = is_signed ? (mac_s[32] ^ mac_s[31]) : mac_u[32];
	end

	// division started by an operate instruction in a division mode
	assign div_start = operate_and_read_instruction && !div_busy
		&& (op == mdm_pkg::OP_DIV_U || op == mdm_pkg::OP_DIV_S);

	div_core u_div (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.start     (div_start),
		.signed_op (is_signed),
		.dividend  (result_register_zero),
		.divisor   ({operand_a, operand_b}),
		.busy      (div_busy),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// next value of both result registers; default holds them
	always_comb begin
		r0_next = result_register_zero;
		r1_next = result_register_one;
		if (div_done) begin
			r0_next = div_quo;
			r1_next = div_rem;
		end else if (operate_and_read_instruction && !div_busy) begin
			case (op)
				mdm_pkg::OP_CLEAR: begin
					r0_next = mdm_pkg::RESULT_RESET;
					r1_next = mdm_pkg::RESULT_RESET;
				end
				mdm_pkg::OP_LOAD16: begin
					r0_next = {result_register_zero[31:16], operand_b};
				end
				mdm_pkg::OP_MUL_U, mdm_pkg::OP_MUL_S: begin
					r0_next = prod;
				end
				mdm_pkg::OP_MAC_U, mdm_pkg::OP_MAC_S: begin
					r0_next = mac_sum;
				end
				default: begin
					r0_next = result_register_zero;
				end
			endcase
		end else if (preload_result_instruction && !div_busy) begin
			// preload carries upper half in operand_a, lower in operand_b
			if (op == mdm_pkg::OP_LOAD32_0) begin
				r0_next = {operand_a, operand_b};
			end else if (op == mdm_pkg::OP_LOAD32_1) begin
				r1_next = {operand_a, operand_b};
			end
		end
	end

	// result registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			result_register_zero <= mdm_pkg::RESULT_RESET;
			result_register_one  <= mdm_pkg::RESULT_RESET;
		end else begin
			result_register_zero <= r0_next;
			result_register_one  <= r1_next;
		end
	end

	// flags: cleared for multiply and divide, overflow only from accumulate
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flags_reg <= 4'h0;
		end else if (operate_and_read_instruction && !div_busy) begin
			case (op)
				mdm_pkg::OP_MUL_U, mdm_pkg::OP_MUL_S: begin
					flags_reg <= 4'h0;
				end
				mdm_pkg::OP_DIV_U, mdm_pkg::OP_DIV_S: begin
					flags_reg <= 4'h0;
				end
				mdm_pkg::OP_MAC_U, mdm_pkg::OP_MAC_S: begin
					flags_reg <= {1'b0, mac_ovf, 2'b00};
				end
				default: begin
					flags_reg <= flags_reg;
				end
			endcase
		end
	end

	// output half picked from the values the registers are about to hold,
	// so the answer of an operation appears together with its result
	always_comb begin
		case (outsel)
			mdm_pkg::OUT_R0_LO: out_next = r0_next[15:0];
			mdm_pkg::OUT_R0_HI: out_next = r0_next[31:16];
			mdm_pkg::OUT_R1_LO: out_next = r1_next[15:0];
			mdm_pkg::OUT_R1_HI: out_next = r1_next[31:16];
			default:            out_next = 16'h0000; // reserved selections
		endcase
	end

	// output register; read mode just presents, no arithmetic
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			out_reg <= 16'h0000;
		end else begin
			out_reg <= out_next;
		end
	end

	// busy held from division start until the result lands
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			out_pending_reg <= 1'b0;
		end else begin
			out_pending_reg <= div_start | (out_pending_reg & ~div_done);
		end
	end

	assign copro_out = out_reg;
	assign carry_overflow_zero_negative_flags = flags_reg;
	assign busy      = out_pending_reg;
	assign mode_out  = operation_output_mode_select_reg;

	// helper counter for the division latency window
	logic [5:0] div_cnt;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			div_cnt <= 6'h00;
		end else if (div_start) begin
			div_cnt <= 6'h01;
		end else if (out_pending_reg) begin
			div_cnt <= 6'(div_cnt + 6'h01);
		end
	end

	sequence s_div_go;
		div_start;
	endsequence
	sequence s_div_end;
		##[17:20] div_done;
	endsequence

	property p_mul_unsigned;
		@(posedge clk_sys) disable iff (!nrst)
		(operate_and_read_instruction && !div_busy && op == mdm_pkg::OP_MUL_U)
		|=> result_register_zero == $past(prod_u);
	endproperty
	a_mul_unsigned: assert property (p_mul_unsigned) else $error("unsigned product wrong");

	property p_mac;
		@(posedge clk_sys) disable iff (!nrst)
		(operate_and_read_instruction && !div_busy && op[3:1] == 3'h3)
		|=> result_register_zero == $past(mac_sum) && flags_reg[2] == $past(mac_ovf);
	endproperty
	a_mac: assert property (p_mac) else $error("accumulate wrong");

	property p_div_time;
		@(posedge clk_sys) disable iff (!nrst)
		s_div_go |-> s_div_end;
	endproperty
	a_div_time: assert property (p_div_time) else $error("division latency out of range");

	property p_div_cnt;
		@(posedge clk_sys) disable iff (!nrst)
		div_done |-> div_cnt >= 6'h11 && div_cnt <= 6'h14;
	endproperty
	a_div_cnt: assert property (p_div_cnt) else $error("division count out of range");

	property p_clear;
		@(posedge clk_sys) disable iff (!nrst)
		(operate_and_read_instruction && !div_busy && !div_done && op == mdm_pkg::OP_CLEAR)
		|=> result_register_zero == 32'h0000_0000 && result_register_one == 32'h0000_0000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	property p_load1;
		@(posedge clk_sys) disable iff (!nrst)
		(preload_result_instruction && !operate_and_read_instruction && !div_busy && !div_done
			&& op == mdm_pkg::OP_LOAD32_1)
		|=> result_register_one == {$past(operand_a), $past(operand_b)};
	endproperty
	a_load1: assert property (p_load1) else $error("load of result one failed");

	property p_mul_flags;
		@(posedge clk_sys) disable iff (!nrst)
		(operate_and_read_instruction && !div_busy && op[3:1] == 3'h2)
		|=> carry_overflow_zero_negative_flags == 4'h0;
	endproperty
	a_mul_flags: assert property (p_mul_flags) else $error("flags not cleared");

	property p_hold;
		@(posedge clk_sys) disable iff (!nrst)
		(!operate_and_read_instruction && !preload_result_instruction && !div_done)
		|=> $stable(result_register_zero) && $stable(result_register_one);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without operation");

	property p_reserved;
		@(posedge clk_sys) disable iff (!nrst)
		(operate_and_read_instruction && !div_busy && !div_done && op > mdm_pkg::OP_LOAD32_1)
		|=> $stable(result_register_zero) && $stable(result_register_one) && $stable(flags_reg);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved op changed state");
endmodule
`default_nettype wire

// ===== test/core_model.sv
/*
 * core-side model: issues mode writes, operate and preload instructions.
 * assumes the coprocessor samples one-cycle pulses on rising clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic        clk_sys,
	input  wire logic        busy,
	output var  logic        mode_write_instruction,
	output var  logic [6:0]  mode_data,
	output var  logic        operate_and_read_instruction,
	output var  logic        preload_result_instruction,
	output var  logic [15:0] operand_a,
	output var  logic [15:0] operand_b,
	output var  logic        stuck
);
	// idle at time zero
	initial begin
		mode_write_instruction = 1'b0;
		operate_and_read_instruction = 1'b0;
		preload_result_instruction = 1'b0;
		mode_data = 7'h00;
		operand_a = 16'h0000;
		operand_b = 16'h0000;
		stuck = 1'b0;
	end

	// kind: bit0 mode write, bit1 operate, bit2 preload; one taking edge each
	task automatic issue(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] b);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		// no instruction while a division runs; bounded so a hang is seen
		while (busy && n < 40) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (busy)
			stuck = 1'b1;
		mode_data = b[6:0];
		operand_a = a;
		operand_b = b;
		mode_write_instruction = kind[0];
		operate_and_read_instruction = kind[1];
		preload_result_instruction = kind[2];
		@(posedge clk_sys);
		#1;
		mode_write_instruction = 1'b0;
		operate_and_read_instruction = 1'b0;
		preload_result_instruction = 1'b0;
		// released lines show junk so stale data never passes for valid
		mode_data = ~b[6:0];
		operand_a = ~a;
		operand_b = ~b;
	endtask
endmodule
`default_nettype wire

// ===== test/mul_div_mac_coprocessor_tb_top.sv
/*
 * self-checking bench: random and corner multiply, mac and divide runs.
 * assumes core_model drives the instruction side of the coprocessor.
 */
`timescale 1ns/100ps
`default_nettype none
module mul_div_mac_coprocessor_tb_top;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        mode_wr, op_go, pre_go, busy, stuck;
	logic [6:0]  mode_d, mode_q;
	logic [15:0] opa, opb, cout;
	logic [3:0]  flags;
	logic [31:0] exp_r0, exp_r1;
	int          fails = 0;
	int          num_checks = 0;

	always #5 clk_sys = ~clk_sys;

	core_model core (.clk_sys(clk_sys), .busy(busy), .mode_write_instruction(mode_wr), .mode_data(mode_d),
		.operate_and_read_instruction(op_go), .preload_result_instruction(pre_go),
		.operand_a(opa), .operand_b(opb), .stuck(stuck));

	mul_div_mac_coprocessor uut (.clk_sys(clk_sys), .nrst(nrst), .mode_write_instruction(mode_wr),
		.mode_data(mode_d), .operate_and_read_instruction(op_go), .preload_result_instruction(pre_go),
		.operand_a(opa), .operand_b(opb), .copro_out(cout), .carry_overflow_zero_negative_flags(flags),
		.busy(busy), .mode_out(mode_q));

	function automatic logic [31:0] mulx(input logic [15:0] a, input logic [15:0] b, input logic s);
		return s ? {{16{a[15]}}, a} * {{16{b[15]}}, b} : {16'h0000, a} * {16'h0000, b};
	endfunction

	// corners often, so overflow and sign cases come up
	function automatic logic [15:0] pick();
		case ($urandom % 4)
			0: return 16'hFFFF;
			1: return 16'h8000;
			default: return 16'($urandom);
		endcase
	endfunction

	task automatic wr(input logic [6:0] m);
		core.issue(3'b001, 16'($urandom), {9'($urandom), m});
	endtask

	task automatic op(input logic [15:0] a, input logic [15:0] b);
		core.issue(3'b010, a, b);
	endtask

	task automatic pl(input logic [15:0] a, input logic [15:0] b);
		core.issue(3'b100, a, b);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// walk all four halves through read mode
	task automatic read_all();
		logic [31:0] w;
		for (int i = 0; i < 4; i++) begin
			wr({3'(i), 4'h3});
			// output half follows the new select one edge after the mode word
			op(16'($urandom), 16'($urandom));
			w = i[1] ? exp_r1 : exp_r0;
			check({16'h0000, cout}, {16'h0000, i[0] ? w[31:16] : w[15:0]});
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge stuck) begin
		fails++;
		wrap_up();
	end

	initial begin
		logic [31:0] p, d, v, q, r, acc;
		logic [32:0] sum;
		logic [15:0] a, b;
		logic [3:0]  fl;
		logic        s, ov;
		int          n;
		void'($urandom(32'hCFE1F2A1));
		repeat (3) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		check({9'h000, mode_q, cout}, 32'h0);
		check({27'h0, busy, flags}, 32'h0);
		exp_r0 = $urandom;
		exp_r1 = $urandom;
		wr(7'h02);
		pl(exp_r0[31:16], exp_r0[15:0]);
		wr(7'h0A);
		pl(exp_r1[31:16], exp_r1[15:0]);
		read_all();
		wr(7'h00);
		op(pick(), pick());
		exp_r0 = 32'h0;
		exp_r1 = 32'h0;
		read_all();
		for (int it = 0; it < 60; it++) begin
			s = 1'($urandom);
			a = pick();
			b = pick();
			p = mulx(a, b, s);
			case ($urandom % 3)
				0: begin
					wr({3'h0, 3'h2, s});
					op(a, b);
					exp_r0 = p;
					check({16'h0000, cout}, {16'h0000, p[15:0]});
					check({28'h0, flags}, 32'h0);
				end
				1: begin
					case ($urandom % 3)
						0: acc = 32'hFFFF_FFFF;
						1: acc = 32'h7FFF_FFFF;
						default: acc = $urandom;
					endcase
					if ($urandom % 4 == 0) begin
						wr(7'h00);
						op(a, b);
						wr(7'h01);
						op(a, acc[15:0]);
						acc = {16'h0000, acc[15:0]};
						exp_r1 = 32'h0;
					end else begin
						wr(7'h02);
						pl(acc[31:16], acc[15:0]);
					end
					sum = {1'b0, acc} + {1'b0, p};
					ov = s ? (acc[31] == p[31] && sum[31] != acc[31]) : sum[32];
					wr({3'h0, 3'h3, s});
					op(a, b);
					exp_r0 = sum[31:0];
					check({16'h0000, cout}, {16'h0000, sum[15:0]});
					check({28'h0, flags}, {28'h0, 1'b0, ov, 2'b00});
				end
				default: begin
					d = $urandom;
					v = $urandom >> ($urandom % 32);
					// the core steers clear of zero divisors and signed overflow
					if (v == 0 || (s && d == 32'h8000_0000 && v == 32'hFFFF_FFFF))
						v = 32'h3;
					if (s) begin
						q = $signed(d) / $signed(v);
						r = $signed(d) % $signed(v);
					end else begin
						q = d / v;
						r = d % v;
					end
					wr(7'h02);
					pl(d[31:16], d[15:0]);
					wr({3'h0, 3'h4, s});
					op(v[31:16], v[15:0]);
					n = 0;
					do begin
						@(posedge clk_sys);
						#1;
						n++;
					end while (busy && n < 40);
					// busy drops at the edge the result lands
					check({31'h0, n >= 17 && n <= 20}, 32'h1);
					exp_r0 = q;
					exp_r1 = r;
					check({16'h0000, cout}, {16'h0000, q[15:0]});
				end
			endcase
			read_all();
		end
		fl = flags;
		for (int o = 11; o < 16; o++) begin
			wr({3'h0, 4'(o)});
			check({25'h0, mode_q}, {28'h0, 4'(o)});
			op(pick(), pick());
			pl(pick(), pick());
			check({28'h0, flags}, {28'h0, fl});
		end
		read_all();
		wrap_up();
	end
endmodule
`default_nettype wire
